/* File: hw/sdc_dev.sv */
`timescale 1ns/1ps
module sdc_dev #(
   parameter int PROG_CYC = sdc_pkg::PD_PROG_CYC
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   sdc_link_if.dev         lnk,
   output logic            ready_o,
   output logic            row_open_o,
   output logic            powered_down_o,
   output logic            pd_busy_o,
   output logic [7:0]      pd_byte_o,
   output logic            cl3_o
);
   sdc_pkg::sdc_cmd_t cmd_q;
   logic [11:0] addr_q;
   logic [1:0]  dqm_q, dqm_q2, bl_code;
   logic [15:0] dq_q, s0, s1;
   logic [15:0] mem [sdc_pkg::MEM_D];
   logic        cke_q, cke_qq, rd_on, wr_on, ap_arm, v0, v1, ref_one;
   logic [3:0]  bcol;
   logic [2:0]  bleft;
   logic [1:0]  row_q;
   logic [3:0]  ap_cnt;

   // input register: one extra cycle on every input
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         cmd_q  <= sdc_pkg::CMD_NOP;
         addr_q <= 12'h000;
         dqm_q  <= 2'h3;
         dqm_q2 <= 2'h3;
         dq_q   <= 16'h0000;
         cke_q  <= 1'b0;
         cke_qq <= 1'b0;
      end
      else if (ce_i)
      begin
         cmd_q  <= sdc_pkg::sdc_cmd_t'(lnk.cmd_n);
         addr_q <= lnk.addr;
         dqm_q  <= lnk.dqm;
         dqm_q2 <= dqm_q;
         dq_q   <= lnk.dq;
         cke_q  <= lnk.cke;
         cke_qq <= cke_q;
      end

   // clock enable acts one cycle after it is registered
   wire run    = ce_i & cke_qq;
   wire is_rd  = cmd_q == sdc_pkg::CMD_RD;
   wire is_wr  = cmd_q == sdc_pkg::CMD_WR;
   wire col_c  = is_rd | is_wr;
   wire stop   = col_c | cmd_q == sdc_pkg::CMD_PRE |
                 cmd_q == sdc_pkg::CMD_BST;
   wire do_rd  = is_rd | (rd_on & ~stop);
   wire do_wr  = is_wr | (wr_on & ~stop);
   wire [3:0] cur_col = col_c ? addr_q[3:0] : bcol;
   wire [2:0] bl_m1 = 3'((4'h1 << bl_code) - 4'h1);
   wire [2:0] left = col_c ? bl_m1 : bleft;
   wire last  = (do_rd | do_wr) & left == 3'h0;
   wire [5:0] idx = {row_q, cur_col};
   wire pre_c = cmd_q == sdc_pkg::CMD_PRE;

   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         rd_on <= 1'b0;
         wr_on <= 1'b0;
         bcol  <= 4'h0;
         bleft <= 3'h0;
         ap_arm <= 1'b0;
         ap_cnt <= 4'h0;
         row_q <= 2'h0;
         row_open_o <= 1'b0;
      end
      else if (run)
      begin
         rd_on <= do_rd & left != 3'h0;
         wr_on <= do_wr & left != 3'h0;
         bcol  <= cur_col + 4'h1;
         bleft <= left - 3'h1;
         if (col_c)
            ap_arm <= addr_q[sdc_pkg::AP_BIT];
         // auto precharge starts after a clock plus the fixed delay
         if (last & (col_c ? addr_q[sdc_pkg::AP_BIT] : ap_arm))
            ap_cnt <= 4'(sdc_pkg::AP_CYC + sdc_pkg::RP_CYC);
         else if (ap_cnt != 4'h0)
            ap_cnt <= ap_cnt - 4'h1;
         if (cmd_q == sdc_pkg::CMD_ACT)
         begin
            row_open_o <= 1'b1;
            row_q <= addr_q[1:0];
         end
         else if (pre_c | ap_cnt == 4'h1)
            row_open_o <= 1'b0;
      end

   // byte mask applies to the word of the same cycle
   always_ff @(posedge clk_sys_i)
      if (run & do_wr)
         for (int b = 0; b < 2; b++)
            if (!dqm_q[b])
               mem[idx][b*8 +: 8] <= dq_q[b*8 +: 8];

   // read pipe; a precharge stops the burst, bus floats cl later
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         s0 <= 16'h0000;
         s1 <= 16'h0000;
         v0 <= 1'b0;
         v1 <= 1'b0;
         lnk.dq_d <= 16'h0000;
         lnk.dq_d_oe_n <= 2'h3;
      end
      else if (run)
      begin
         s0 <= mem[idx];
         v0 <= do_rd;
         s1 <= s0;
         v1 <= v0;
         lnk.dq_d <= cl3_o ? s1 : s0;
         // mask floats the byte two cycles later
         lnk.dq_d_oe_n <= ~({2{cl3_o ? v1 : v0}} & ~dqm_q2);
      end

   // mode word and wake-up refresh tracking
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         cl3_o <= 1'b0;
         bl_code <= 2'h0;
         ref_one <= 1'b0;
         ready_o <= 1'b0;
         powered_down_o <= 1'b1;
      end
      else if (ce_i)
      begin
         powered_down_o <= ~cke_q;
         if (cke_qq & cmd_q == sdc_pkg::CMD_LMR)
         begin
            cl3_o <= addr_q[sdc_pkg::MR_CL_LSB +: 3] == sdc_pkg::CL3_CODE;
            bl_code <= addr_q[sdc_pkg::MR_BL_LSB +: 2];
         end
         if (cke_qq & cmd_q == sdc_pkg::CMD_REF)
         begin
            ref_one <= 1'b1;
            ready_o <= ready_o | ref_one;
         end
      end

   // presence-detect store
   logic scl_p, sda_p, pd_in;
   logic [3:0] pd_bit;
   logic [7:0] pd_sh;
   logic [17:0] pd_cnt;
   wire p_start = lnk.pd_scl & scl_p & sda_p & ~lnk.pd_sda;
   wire p_stop  = lnk.pd_scl & scl_p & ~sda_p & lnk.pd_sda;
   wire p_rise  = lnk.pd_scl & ~scl_p;
   wire p_fall  = ~lnk.pd_scl & scl_p;

   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         pd_in <= 1'b0;
         pd_bit <= 4'h0;
         pd_sh <= 8'h00;
         pd_cnt <= 18'h00000;
         pd_busy_o <= 1'b0;
         pd_byte_o <= 8'h00;
         lnk.pd_sda_d_o <= 1'b1;
         lnk.pd_sda_d_oe_n <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_p <= lnk.pd_scl;
         sda_p <= lnk.pd_sda;
         // program cycle: bus ignored, byte not acknowledged
         if (pd_busy_o)
         begin
            pd_cnt <= pd_cnt - 18'h00001;
            pd_busy_o <= pd_cnt != 18'h00001;
         end
         else if (p_start)
         begin
            pd_in <= 1'b1;
            pd_bit <= 4'h0;
         end
         else if (p_stop & pd_in)
         begin
            pd_in <= 1'b0;
            if (pd_bit == 4'h9)
            begin
               pd_byte_o <= pd_sh;
               pd_busy_o <= 1'b1;
               pd_cnt <= 18'(PROG_CYC);
            end
         end
         else if (pd_in & p_rise & pd_bit < 4'h8)
         begin
            pd_sh <= {pd_sh[6:0], lnk.pd_sda};
            pd_bit <= pd_bit + 4'h1;
         end
         else if (pd_in & p_fall & pd_bit == 4'h8)
         begin
            lnk.pd_sda_d_o <= 1'b0;
            lnk.pd_sda_d_oe_n <= 1'b0;
            pd_bit <= 4'h9;
         end
         else if (p_fall)
         begin
            lnk.pd_sda_d_o <= 1'b1;
            lnk.pd_sda_d_oe_n <= 1'b1;
         end
      end
endmodule // sdc_dev

/* File: hw/sdc_host.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - column commands may follow every cycle
// - clock enable change acts one cycle later
// - write mask blocks same-cycle data word
// - read mask floats outputs two cycles later
// - first write data with write command
// - wait five cycles, last data to activate
// - wait two cycles, last data to precharge
// - burst stop one cycle after data
// - new column command one cycle after data
// - three cycles after mode load
// - precharge floats read outputs after latency
// - 100us pause, two refreshes, repeat when late
// - input register adds one cycle everywhere
// - clock steady; use clock enable instead
// - auto precharge starts clock plus delay
// - store busy ten ms, ignores its bus
// - serial clock no faster than 100 kHz
module sdc_host (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   sdc_link_if.host         lnk,
   input  wire logic        cke_i,
   input  wire logic        req_valid_i,
   input  wire logic        req_write_i,
   input  wire logic [11:0] req_row_i,
   input  wire logic [7:0]  req_col_i,
   input  wire logic [15:0] req_data_i,
   input  wire logic [1:0]  req_mask_i,
   output logic             req_ready_o,
   output logic [15:0]      rd_data_o,
   output logic             rd_valid_o,
   input  wire logic        rd_ready_i,
   output logic             init_done_o,
   input  wire logic        pd_wr_i,
   input  wire logic [7:0]  pd_byte_i,
   output logic             pd_done_o,
   output logic             pd_nack_o
);
   localparam int RD_CAP = sdc_pkg::HOST_CL + 1;

   sdc_pkg::sdc_hst_t st, ret, next_st, next_ret;
   sdc_pkg::sdc_cmd_t cmd, next_cmd;
   logic [11:0] wcnt, next_wcnt, addr, next_addr;
   logic        cke, next_cke, next_dq_oe_n, dq_oe_n;
   logic [8:0]  refc;
   logic [1:0]  owed;
   logic        op_wr;
   logic [15:0] op_data;
   logic [1:0]  op_mask, dqm;
   logic [7:0]  req_col_q;
   logic [RD_CAP:0] rdp;
   logic [15:0] e1;
   logic [1:0]  fcnt, next_fcnt;

   function automatic sdc_pkg::sdc_hst_t hold_for(input int n,
                                  input sdc_pkg::sdc_hst_t x);
      return (n > 1) ? sdc_pkg::H_WAIT : x;
   endfunction

   wire acc = st == sdc_pkg::H_IDLE & req_valid_i & req_ready_o;
   wire push = rdp[RD_CAP];
   wire pop = rd_valid_o & rd_ready_i;
   wire ref_tick = init_done_o & refc == 9'(sdc_pkg::REFI_CYC - 1);

   always_comb
   begin
      next_st = st;
      next_ret = ret;
      next_wcnt = wcnt - 12'h001;
      next_cmd = sdc_pkg::CMD_NOP;
      next_addr = addr;
      next_cke = cke;
      next_dq_oe_n = 1'b1;
      case (st)
         // power-up pause, then precharge all
         sdc_pkg::H_PWR:
            if (wcnt == 12'h000)
               next_st = sdc_pkg::H_PALL;
         sdc_pkg::H_PALL:
         begin
            next_cmd = sdc_pkg::CMD_PRE;
            next_addr = sdc_pkg::A_ALL;
            next_st = hold_for(sdc_pkg::RP_CYC, sdc_pkg::H_REF1);
            next_ret = sdc_pkg::H_REF1;
            next_wcnt = 12'(sdc_pkg::RP_CYC - 2);
         end
         // two wake-up refreshes
         sdc_pkg::H_REF1, sdc_pkg::H_REF2:
         begin
            next_cmd = sdc_pkg::CMD_REF;
            next_ret = (st == sdc_pkg::H_REF1) ? sdc_pkg::H_REF2
                                               : sdc_pkg::H_LMR;
            next_st = hold_for(sdc_pkg::RFC_CYC, next_ret);
            next_wcnt = 12'(sdc_pkg::RFC_CYC - 2);
         end
         // mode load then the longer recommended gap
         sdc_pkg::H_LMR:
         begin
            next_cmd = sdc_pkg::CMD_LMR;
            next_addr = sdc_pkg::MR_HOST;
            next_st = hold_for(sdc_pkg::LMR_CYC, sdc_pkg::H_IDLE);
            next_ret = sdc_pkg::H_IDLE;
            next_wcnt = 12'(sdc_pkg::LMR_CYC - 2);
         end
         sdc_pkg::H_IDLE:
            if (acc)
            begin
               next_cmd = sdc_pkg::CMD_ACT;
               next_addr = req_row_i;
               next_st = hold_for(sdc_pkg::RCD_CYC, sdc_pkg::H_COL);
               next_ret = sdc_pkg::H_COL;
               next_wcnt = 12'(sdc_pkg::RCD_CYC - 2);
            end
            // late refreshes are made up back to back
            else if (owed != 2'h0)
               next_st = sdc_pkg::H_REF;
            // slow down through clock enable, never the clock
            else if (!cke_i)
            begin
               next_cke = 1'b0;
               next_st = sdc_pkg::H_SUSP;
            end
         // write data rides with the command, one word
         sdc_pkg::H_COL:
         begin
            next_cmd = op_wr ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD;
            next_addr = {4'h0, req_col_q};
            next_dq_oe_n = ~op_wr;
            // last data to precharge spacing
            next_st = hold_for(sdc_pkg::DIN_PRE_CYC, sdc_pkg::H_PRE);
            next_ret = sdc_pkg::H_PRE;
            next_wcnt = 12'(sdc_pkg::DIN_PRE_CYC - 2);
         end
         // remaining spacing to next activate
         sdc_pkg::H_PRE:
         begin
            next_cmd = sdc_pkg::CMD_PRE;
            next_addr = 12'h000;
            next_st = hold_for(sdc_pkg::PRE_ACT_CYC, sdc_pkg::H_IDLE);
            next_ret = sdc_pkg::H_IDLE;
            next_wcnt = 12'(sdc_pkg::PRE_ACT_CYC - 2);
         end
         sdc_pkg::H_REF:
         begin
            next_cmd = sdc_pkg::CMD_REF;
            next_st = hold_for(sdc_pkg::RFC_CYC, sdc_pkg::H_IDLE);
            next_ret = sdc_pkg::H_IDLE;
            next_wcnt = 12'(sdc_pkg::RFC_CYC - 2);
         end
         // device acts on clock enable a cycle late
         sdc_pkg::H_SUSP:
            if (cke_i)
            begin
               next_cke = 1'b1;
               next_st = hold_for(sdc_pkg::CKE_LAT, sdc_pkg::H_IDLE);
               next_ret = sdc_pkg::H_IDLE;
               next_wcnt = 12'(sdc_pkg::CKE_LAT - 2);
            end
         sdc_pkg::H_WAIT:
            if (wcnt == 12'h000)
               next_st = ret;
         default:
            next_st = sdc_pkg::H_PWR;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         st <= sdc_pkg::H_PWR;
         ret <= sdc_pkg::H_PWR;
         wcnt <= 12'(sdc_pkg::PWR_CYC - 1);
         cmd <= sdc_pkg::CMD_NOP;
         addr <= 12'h000;
         cke <= 1'b1;
         dq_oe_n <= 1'b1;
         init_done_o <= 1'b0;
         req_ready_o <= 1'b0;
      end
      else if (ce_i)
      begin
         st <= next_st;
         ret <= next_ret;
         wcnt <= next_wcnt;
         cmd <= next_cmd;
         addr <= next_addr;
         cke <= next_cke;
         dq_oe_n <= next_dq_oe_n;
         if (next_st == sdc_pkg::H_IDLE)
            init_done_o <= 1'b1;
         req_ready_o <= next_st == sdc_pkg::H_IDLE & owed == 2'h0 &
                        cke_i & (next_fcnt == 2'h0 |
                        (next_fcnt == 2'h1 & rdp[RD_CAP-1:0] == '0));
      end

   // latched request, mask sent beside its data
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         op_wr <= 1'b0;
         op_data <= 16'h0000;
         op_mask <= 2'h0;
         req_col_q <= 8'h00;
         dqm <= 2'h0;
      end
      else if (ce_i)
      begin
         if (acc)
         begin
            op_wr <= req_write_i;
            op_data <= req_data_i;
            op_mask <= req_mask_i;
            req_col_q <= req_col_i;
         end
         dqm <= (st == sdc_pkg::H_COL & op_wr) ? op_mask : 2'h0;
      end

   // refresh interval count, owed refreshes saturate at two
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         refc <= 9'h000;
         owed <= 2'h0;
      end
      else if (ce_i)
      begin
         refc <= ref_tick ? 9'h000 : (init_done_o ? refc + 9'h001 : refc);
         if (ref_tick & owed != 2'h2)
            owed <= owed + 2'h1;
         else if (!ref_tick & st == sdc_pkg::H_REF)
            owed <= owed - 2'h1;
      end

   // read data lands one cycle past cas latency
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
         rdp <= '0;
      else if (ce_i)
         rdp <= {rdp[RD_CAP-1:0], next_cmd == sdc_pkg::CMD_RD};

   // two-entry read buffer, head is the output register
   always_comb
   begin
      next_fcnt = fcnt;
      if (push & !pop)
         next_fcnt = fcnt + 2'h1;
      else if (pop & !push)
         next_fcnt = fcnt - 2'h1;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         fcnt <= 2'h0;
         rd_data_o <= 16'h0000;
         e1 <= 16'h0000;
         rd_valid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         fcnt <= next_fcnt;
         rd_valid_o <= next_fcnt != 2'h0;
         if (pop)
            rd_data_o <= (push & fcnt == 2'h1) ? lnk.dq : e1;
         else if (push & fcnt == 2'h0)
            rd_data_o <= lnk.dq;
         if (push & (fcnt == 2'h1 + 2'(pop)))
            e1 <= lnk.dq;
      end

   assign lnk.cke = cke;
   assign lnk.cmd_n = cmd;
   assign lnk.addr = addr;
   assign lnk.dqm = dqm;
   assign lnk.dq_h = op_data;
   assign lnk.dq_h_oe_n = dq_oe_n;

   // serial store writer, half period rounded up
   logic        pd_on;
   logic [4:0]  pd_step;
   logic [7:0]  pd_div;
   logic [7:0]  pd_sh;
   wire pd_tick = pd_div == 8'(sdc_pkg::PD_HALF_CYC - 1);
   wire [3:0] bitn = 4'((pd_step - 5'h1) >> 1);
   wire in_bits = pd_step != 5'h0 & pd_step <= sdc_pkg::PD_ACK_STEP;
   wire scl_v = ~pd_on | (in_bits ? ~pd_step[0] : pd_step != 5'h13);
   wire sda_v = ~pd_on | (in_bits ? (bitn[3] | pd_sh[3'h7 - bitn[2:0]])
                                  : pd_step == sdc_pkg::PD_LAST_STEP);

   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         pd_on <= 1'b0;
         pd_step <= 5'h00;
         pd_div <= 8'h00;
         pd_sh <= 8'h00;
         pd_done_o <= 1'b0;
         pd_nack_o <= 1'b0;
         lnk.pd_scl <= 1'b1;
         lnk.pd_sda_h_o <= 1'b1;
         lnk.pd_sda_h_oe_n <= 1'b1;
      end
      else if (ce_i)
      begin
         pd_done_o <= 1'b0;
         lnk.pd_scl <= scl_v;
         lnk.pd_sda_h_o <= sda_v;
         lnk.pd_sda_h_oe_n <= sda_v;
         if (!pd_on & pd_wr_i)
         begin
            pd_on <= 1'b1;
            pd_sh <= pd_byte_i;
            pd_step <= 5'h00;
            pd_div <= 8'h00;
         end
         else if (pd_on)
         begin
            pd_div <= pd_tick ? 8'h00 : pd_div + 8'h01;
            if (pd_tick)
            begin
               if (pd_step == sdc_pkg::PD_ACK_STEP)
                  pd_nack_o <= lnk.pd_sda;
               pd_step <= pd_step + 5'h01;
               if (pd_step == sdc_pkg::PD_LAST_STEP)
               begin
                  pd_on <= 1'b0;
                  pd_done_o <= 1'b1;
               end
            end
         end
      end
endmodule // sdc_host

/* File: hw/sdc_link_if.sv */
`timescale 1ns/1ps
interface sdc_link_if;
   logic        cke;
   logic [3:0]  cmd_n;
   logic [11:0] addr;
   logic [1:0]  dqm;
   logic [15:0] dq_h;
   logic        dq_h_oe_n;
   logic [15:0] dq_d;
   logic [1:0]  dq_d_oe_n;
   logic [15:0] dq;
   logic        pd_scl;
   logic        pd_sda_h_o;
   logic        pd_sda_h_oe_n;
   logic        pd_sda_d_o;
   logic        pd_sda_d_oe_n;
   logic        pd_sda;

   // shared data wire, idle level high
   always_comb
   begin
      for (int b = 0; b < 2; b++)
      begin
         if (!dq_h_oe_n)
            dq[b*8 +: 8] = dq_h[b*8 +: 8];
         else if (!dq_d_oe_n[b])
            dq[b*8 +: 8] = dq_d[b*8 +: 8];
         else
            dq[b*8 +: 8] = 8'hff;
      end
   end

   // open-drain serial data with pull-up
   assign pd_sda = ~((~pd_sda_h_oe_n & ~pd_sda_h_o) |
                     (~pd_sda_d_oe_n & ~pd_sda_d_o));

   modport dev (input cke, cmd_n, addr, dqm, dq, pd_scl, pd_sda,
                output dq_d, dq_d_oe_n, pd_sda_d_o, pd_sda_d_oe_n);
   modport host (output cke, cmd_n, addr, dqm, dq_h, dq_h_oe_n, pd_scl,
                 pd_sda_h_o, pd_sda_h_oe_n,
                 input dq, pd_sda);
endinterface

/* File: hw/sdc_pkg.sv */
package sdc_pkg;
   // link widths
   localparam int DQ_W = 16;
   localparam int DM_W = 2;
   localparam int A_W  = 12;
   localparam int MEM_D = 64;

   // clock period in picoseconds (25 MHz)
   localparam int CLK_PS = 40000;

   // spacings rounded up, intervals rounded down, to whole cycles
   function automatic int sdc_cyc_up(input longint ps);
      longint c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : int'(c);
   endfunction

   function automatic int sdc_cyc_dn(input longint ps);
      longint c;
      c = ps / CLK_PS;
      return (c < 1) ? 1 : int'(c);
   endfunction

   // times in their own units
   localparam int T_PWR_US    = 100;
   localparam int T_REF_MS    = 64;
   localparam int REF_ROWS    = 4096;
   localparam int T_RCD_PS    = 20000;
   localparam int T_RP_PS     = 20000;
   localparam int T_RFC_PS    = 66000;
   localparam int T_AP_PS     = 7500;
   localparam int T_PROG_MS   = 10;
   localparam int PD_SCL_KHZ  = 100;

   // derived cycle counts
   localparam int PWR_CYC  = sdc_cyc_up(longint'(T_PWR_US) * 1000000);
   localparam int REFI_CYC = sdc_cyc_dn(longint'(T_REF_MS) * 1000000000
                                        / REF_ROWS);
   localparam int RCD_CYC  = sdc_cyc_up(T_RCD_PS);
   localparam int RP_CYC   = sdc_cyc_up(T_RP_PS);
   localparam int RFC_CYC  = sdc_cyc_up(T_RFC_PS);
   localparam int AP_CYC   = 1 + sdc_cyc_up(T_AP_PS);
   localparam int PD_PROG_CYC = sdc_cyc_dn(longint'(T_PROG_MS) * 1000000000);
   localparam int PD_HALF_CYC = sdc_cyc_up(longint'(1000000000)
                                           / PD_SCL_KHZ / 2);

   // spacings in clock cycles
   localparam int CCD_CYC     = 1;
   localparam int DIN_ACT_CYC = 5;
   localparam int DIN_PRE_CYC = 2;
   localparam int PRE_ACT_CYC = DIN_ACT_CYC - DIN_PRE_CYC;
   localparam int LMR_CYC     = 3;
   localparam int CKE_LAT     = 1;

   // mode word fields
   localparam int MR_BL_LSB = 0;
   localparam int MR_CL_LSB = 4;
   localparam int AP_BIT    = 10;
   localparam logic [2:0] CL3_CODE = 3'h3;
   localparam int HOST_CL   = 3;
   localparam logic [11:0] MR_HOST = 12'h030;
   localparam logic [11:0] A_ALL   = 12'h400;

   // serial store frame
   localparam logic [4:0] PD_ACK_STEP  = 5'h12;
   localparam logic [4:0] PD_LAST_STEP = 5'h15;

   // {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_LMR  = 4'h0,
      CMD_REF  = 4'h1,
      CMD_PRE  = 4'h2,
      CMD_ACT  = 4'h3,
      CMD_WR   = 4'h4,
      CMD_RD   = 4'h5,
      CMD_BST  = 4'h6,
      CMD_NOP  = 4'h7
   } sdc_cmd_t;

   typedef enum logic [3:0] {
      H_PWR  = 4'h0,
      H_PALL = 4'h1,
      H_REF1 = 4'h2,
      H_REF2 = 4'h3,
      H_LMR  = 4'h4,
      H_IDLE = 4'h5,
      H_ACT  = 4'h6,
      H_COL  = 4'h7,
      H_PRE  = 4'h8,
      H_REF  = 4'h9,
      H_SUSP = 4'ha,
      H_WAIT = 4'hb
   } sdc_hst_t;
endpackage

/* File: test/registered_sdram_cmd_timing_tb_top.sv */
`timescale 1ns/1ps
module registered_sdram_cmd_timing_tb_top;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cke_i = 1'b1;
   logic        req_valid_i = 1'b0;
   logic        req_write_i = 1'b0;
   logic [11:0] req_row_i = 12'h000;
   logic [7:0]  req_col_i = 8'h00;
   logic [15:0] req_data_i = 16'h0000;
   logic [1:0]  req_mask_i = 2'h0;
   logic        rd_ready_i = 1'b1;
   logic        pd_wr_i = 1'b0;
   logic [7:0]  pd_byte_i = 8'h00;
   logic [15:0] rd_data_o;
   logic [7:0]  pd_byte_o;
   logic        req_ready_o, rd_valid_o, init_done_o, pd_done_o, pd_nack_o;
   logic        ready_o, row_open_o, powered_down_o, pd_busy_o, cl3_o;
   int          miscompares = 0;
   int          n_compared = 0;
   sdc_link_if  lnk ();
   always #20 clk_sys_i = ~clk_sys_i;
   sdc_host sdc_host_i (.clk_sys_i, .rst_i, .ce_i(1'b1), .lnk(lnk.host),
      .cke_i, .req_valid_i, .req_write_i, .req_row_i, .req_col_i,
      .req_data_i, .req_mask_i, .req_ready_o, .rd_data_o, .rd_valid_o,
      .rd_ready_i, .init_done_o, .pd_wr_i, .pd_byte_i, .pd_done_o,
      .pd_nack_o);
   sdc_dev #(.PROG_CYC(500)) sdc_dev_i (.clk_sys_i, .rst_i, .ce_i(1'b1),
      .lnk(lnk.dev), .ready_o, .row_open_o, .powered_down_o, .pd_busy_o,
      .pd_byte_o, .cl3_o);
   sdc_link_asserts sdc_link_asserts_i (.clk_sys_i, .rst_i,
      .cmd_n(lnk.cmd_n), .dqm(lnk.dqm), .dq_h_oe_n(lnk.dq_h_oe_n),
      .dq_d_oe_n(lnk.dq_d_oe_n), .pd_scl(lnk.pd_scl));
   task automatic conclude();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // bounded wait: 0 request ready, 1 read word, 2 serial done
   task automatic wait_on(input int sel);
      logic hit;
      for (int n = 0; n < 5000; n++)
      begin
         @(posedge clk_sys_i);
         hit = (sel == 0) ? req_ready_o : (sel == 1) ? rd_valid_o : pd_done_o;
         if (hit === 1'b1)
            return;
      end
      miscompares++;
      $display("unexpected at %0t: wait timed out", $time);
      conclude();
   endtask
   task automatic req(input logic wr, input logic [5:0] adr,
                      input logic [15:0] dat, input logic [1:0] msk);
      @(posedge clk_sys_i);
      req_valid_i <= 1'b1;
      req_write_i <= wr;
      req_row_i   <= {10'h000, adr[5:4]};
      req_col_i   <= {4'h0, adr[3:0]};
      req_data_i  <= dat;
      req_mask_i  <= msk;
      wait_on(0);
      req_valid_i <= 1'b0;
   endtask
   task automatic pd(input logic [7:0] b, input logic nack);
      @(posedge clk_sys_i);
      pd_wr_i   <= 1'b1;
      pd_byte_i <= b;
      @(posedge clk_sys_i);
      pd_wr_i <= 1'b0;
      wait_on(2);
      chk(16'(pd_nack_o), 16'(nack));
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      wait_on(0);
      chk(16'(ready_o), 16'h0001);
      chk(16'(cl3_o), 16'h0001);
      req(1'b1, 6'h05, 16'h1234, 2'h0);
      req(1'b1, 6'h05, 16'habcd, 2'h1);
      req(1'b1, 6'h3a, 16'h1111, 2'h0);
      req(1'b1, 6'h3a, 16'h5678, 2'h2);
      rd_ready_i <= 1'b0;
      req(1'b0, 6'h05, 16'h0000, 2'h0);
      req(1'b0, 6'h3a, 16'h0000, 2'h0);
      repeat (20) @(posedge clk_sys_i);
      chk(16'(req_ready_o), 16'h0000);
      chk(16'(row_open_o), 16'h0000);
      rd_ready_i <= 1'b1;
      wait_on(1);
      chk(rd_data_o, 16'hab34);
      wait_on(1);
      chk(rd_data_o, 16'h1178);
      cke_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      chk(16'(powered_down_o), 16'h0001);
      chk(16'(req_ready_o), 16'h0000);
      cke_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      chk(16'(powered_down_o), 16'h0000);
      req(1'b0, 6'h05, 16'h0000, 2'h0);
      wait_on(1);
      chk(rd_data_o, 16'hab34);
      pd(8'h5a, 1'b0);
      chk(16'(pd_busy_o), 16'h0001);
      pd(8'ha5, 1'b1);
      chk(16'(pd_byte_o), 16'h005a);
      repeat (60) @(posedge clk_sys_i);
      pd(8'h3c, 1'b0);
      chk(16'(pd_byte_o), 16'h003c);
      conclude();
   end
endmodule // registered_sdram_cmd_timing_tb_top

/* File: test/sdc_link_asserts.sv */
`timescale 1ns/1ps
module sdc_link_asserts (
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   input wire logic [3:0] cmd_n,
   input wire logic [1:0] dqm,
   input wire logic       dq_h_oe_n,
   input wire logic [1:0] dq_d_oe_n,
   input wire logic       pd_scl
);
   logic [1:0]  n_ref;
   logic        scl_q;
   logic [15:0] scl_hold;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // refresh count, cycles since serial clock edge
   always_ff @(posedge clk_sys_i or posedge rst_i)
      if (rst_i)
      begin
         n_ref    <= 2'h0;
         scl_q    <= 1'b1;
         scl_hold <= 16'h0000;
      end
      else
      begin
         if (cmd_n == sdc_pkg::CMD_REF && n_ref != 2'h2)
            n_ref <= n_ref + 2'h1;
         scl_q    <= pd_scl;
         scl_hold <= (pd_scl != scl_q) ? 16'h0000 : scl_hold + 16'h0001;
      end
   write_data_a: assert property (cmd_n == sdc_pkg::CMD_WR |-> !dq_h_oe_n)
      else $error("write data missing");
   write_pre_a: assert property (cmd_n == sdc_pkg::CMD_WR |->
      ##1 cmd_n == sdc_pkg::CMD_NOP ##1 cmd_n == sdc_pkg::CMD_PRE)
      else $error("precharge spacing");
   write_act_a: assert property (cmd_n == sdc_pkg::CMD_WR |=>
      (cmd_n != sdc_pkg::CMD_ACT) [*4])
      else $error("activate too early");
   mode_gap_a: assert property (cmd_n == sdc_pkg::CMD_LMR |=>
      (cmd_n != sdc_pkg::CMD_ACT && cmd_n != sdc_pkg::CMD_REF) [*2])
      else $error("mode load gap");
   read_float_a: assert property ((cmd_n == sdc_pkg::CMD_RD && dqm == 2'h0)
      ##1 (dqm == 2'h0) [*3] |=> dq_d_oe_n == 2'h0 ##1 dq_d_oe_n == 2'h3)
      else $error("read data slot");
   bus_clash_a: assert property (!dq_h_oe_n |-> dq_d_oe_n == 2'h3)
      else $error("data bus clash");
   init_ref_a: assert property (cmd_n == sdc_pkg::CMD_ACT |-> n_ref == 2'h2)
      else $error("activate before refreshes");
   scl_rate_a: assert property (pd_scl != scl_q |-> scl_hold >= 16'h0078)
      else $error("serial clock too fast");
endmodule // sdc_link_asserts
